// ===== shared/bus_cmd_params.svh
// command byte codes, address layout, default address and buffer depth for the bus command decoder
// assumes: included by the decoder and its checker by bare name
`ifndef BUS_CMD_PARAMS_SVH
`define BUS_CMD_PARAMS_SVH
`define CMD_GO_LOCAL      8'h01
`define CMD_SEL_CLEAR     8'h04
`define CMD_TRIGGER       8'h08
`define CMD_LOCKOUT       8'h11
`define CMD_DEV_CLEAR     8'h14
`define CMD_POLL_ON       8'h18
`define CMD_POLL_OFF      8'h19
`define CMD_UNLISTEN      8'h3f
`define CMD_UNTALK        8'h5f
`define GRP_LISTEN        3'h1
`define GRP_TALK          3'h2
`define GRP_SECONDARY     3'h3
`define ADDR_MAX          5'h1e
`define ADDR_DEFAULT      5'h0f
`define BUF_DEPTH         2
`endif

// ===== shared/bus_cmd_pkg.sv
// types used by the bus command decoder only
// assumes: no other package
package bus_cmd_pkg;
  // one byte as received or sent, with its end marker
  typedef struct packed
  {
    logic [7:0] data;
    logic       eoi;
  } bus_byte_t;

  typedef enum logic [3:0]
  {
    HS_IDLE  = 4'b0001,
    HS_READY = 4'b0010,
    HS_TAKEN = 4'b0100,
    HS_DONE  = 4'b1000
  } accept_state_t;

  typedef enum logic [3:0]
  {
    SRC_IDLE  = 4'b0001,
    SRC_SETUP = 4'b0010,
    SRC_VALID = 4'b0100,
    SRC_WAIT  = 4'b1000
  } source_state_t;
endpackage

// ===== rtl/bus_cmd_decoder.sv
// instrument-side command decoder for a parallel instrument bus port
// assumes: bus pins already synchronous to i_clk, inverted outputs drive open-collector buffers
//
// Operation
// RULE1 - uniline lines are active low
// RULE2 - remote enable true leaves local mode
// RULE3 - controller sets remote before programming
// RULE4 - end-or-identify marks last byte
// RULE5 - interface clear idles talker and listener
// RULE6 - attention-true bytes decode as commands
// RULE7 - assert service request when attention needed
// RULE8 - universal commands act without addressing
// RULE9 - byte 11 enters local lockout
// RULE10 - byte 14 clears to power-up defaults
// RULE11 - bytes 18/19 enter/leave serial poll
// RULE12 - addressed commands need listener addressing
// RULE13 - byte 04 clears when listening
// RULE14 - byte 01 returns to local when listening
// RULE15 - byte 08 triggers action when listening
// RULE16 - 20-3F listen addresses, match makes listener
// RULE17 - 40-5F talk addresses, match makes talker
// RULE18 - secondary group 60-7F ignored
// RULE19 - 3F unlistens, 5F untalks
// RULE20 - attention-false data delivered only when listening
// RULE21 - controller: unlisten, listen address, command
// RULE22 - controller: address then data with attention false
// RULE23 - interlocked three-wire byte handshake
// RULE24 - primary address 0 to 30
// RULE25 - data lines active low, first is lsb
// RULE26 - serial poll talker sends status byte
// RULE27 - other talk address idles talker
`timescale 1ns/1ps
`include "bus_cmd_params.svh"

module bus_cmd_decoder
#(
  parameter logic [4:0] PRIMARY_ADDR = `ADDR_DEFAULT
)
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // bus side, active low as on the wires except the active-high output enables
  input  wire logic       i_atn_n,
  input  wire logic       i_ifc_n,
  input  wire logic       i_ren_n,
  input  wire logic       i_eoi_n,
  input  wire logic       i_dav_n,
  input  wire logic       i_nrfd_n,
  input  wire logic       i_ndac_n,
  input  wire logic [7:0] i_dio_n,
  output logic [7:0]      o_dio_n,
  output logic            o_dio_oe,
  output logic            o_dav_n,
  output logic            o_dav_oe,
  output logic            o_eoi_n,
  output logic            o_eoi_oe,
  output logic            o_nrfd_n,
  output logic            o_nrfd_oe,
  output logic            o_ndac_n,
  output logic            o_ndac_oe,
  output logic            o_srq_n,
  output logic            o_srq_oe,
  // instrument side
  input  wire logic       i_lockout_cfg,
  input  wire logic       i_local_key,
  input  wire logic       i_srq_req,
  input  wire logic [7:0] i_status,
  input  wire logic [8:0] i_tx,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic [8:0]      o_rx,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  output logic            o_remote,
  output logic            o_lockout,
  output logic            o_panel_locked,
  output logic            o_listener,
  output logic            o_talker,
  output logic            o_poll_mode,
  output logic            o_dev_clear,
  output logic            o_trigger
);

  if (PRIMARY_ADDR > `ADDR_MAX)
  begin : g_addr_check
    $error("primary address above 30");  // see RULE24
  end

  // ----------------------------------------------------------------
  // line decode
  // ----------------------------------------------------------------
  logic       atn, ifc, ren, dav, nrfd, ndac;
  logic [7:0] din;
  assign atn  = ~i_atn_n;  // see RULE1
  assign ifc  = ~i_ifc_n;
  assign ren  = ~i_ren_n;
  assign dav  = ~i_dav_n;
  assign nrfd = ~i_nrfd_n;
  assign ndac = ~i_ndac_n;
  assign din  = ~i_dio_n;  // see RULE25

  bus_cmd_pkg::accept_state_t acc_q;
  bus_cmd_pkg::source_state_t src_q;
  logic listen_q, talk_q, remote_q, llo_q, poll_q, srq_q, poll_sent_q, local_hold_q;
  logic       rxbuf_ready;
  logic       take;
  bus_cmd_pkg::bus_byte_t rx_byte;

  // accept only when the receive buffer has room; attention bytes always fit
  logic can_accept;
  assign can_accept = atn | rxbuf_ready;

  // ----------------------------------------------------------------
  // acceptor handshake
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      acc_q <= bus_cmd_pkg::HS_IDLE;
    else
    begin
      unique case (acc_q)
        bus_cmd_pkg::HS_IDLE:  if (can_accept) acc_q <= bus_cmd_pkg::HS_READY;
        bus_cmd_pkg::HS_READY: if (dav) acc_q <= bus_cmd_pkg::HS_TAKEN;  // see RULE23
        bus_cmd_pkg::HS_TAKEN: acc_q <= bus_cmd_pkg::HS_DONE;
        bus_cmd_pkg::HS_DONE:  if (!dav) acc_q <= bus_cmd_pkg::HS_IDLE;
      endcase
    end
  end

  // only take part when attention is on or this port is addressed to listen
  logic acc_active;
  assign acc_active = atn | listen_q;
  assign take       = (acc_q == bus_cmd_pkg::HS_TAKEN) & acc_active;
  assign rx_byte    = '{data: din, eoi: ~i_eoi_n};  // see RULE4

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_nrfd_n  <= 1'b1;
      o_nrfd_oe <= 1'b0;
      o_ndac_n  <= 1'b1;
      o_ndac_oe <= 1'b0;
    end
    else
    begin
      o_nrfd_oe <= acc_active & (acc_q != bus_cmd_pkg::HS_READY);
      o_nrfd_n  <= ~(acc_active & (acc_q != bus_cmd_pkg::HS_READY));
      o_ndac_oe <= acc_active & (acc_q != bus_cmd_pkg::HS_DONE);
      o_ndac_n  <= ~(acc_active & (acc_q != bus_cmd_pkg::HS_DONE));
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic cmd, is_clear, is_local;
  assign cmd      = take & atn;  // see RULE6
  assign is_clear = cmd & ((din == `CMD_DEV_CLEAR) | (listen_q & din == `CMD_SEL_CLEAR));  // see RULE10 see RULE13
  assign is_local = cmd & listen_q & (din == `CMD_GO_LOCAL);  // see RULE12 see RULE14

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || ifc)  // see RULE5
    begin
      listen_q <= 1'b0;
      talk_q   <= 1'b0;
    end
    else if (cmd && din[7:5] == `GRP_LISTEN)
    begin
      if (din == `CMD_UNLISTEN)
        listen_q <= 1'b0;  // see RULE19
      else if (din[4:0] == PRIMARY_ADDR)
        listen_q <= 1'b1;  // see RULE16
    end
    else if (cmd && din[7:5] == `GRP_TALK)
    begin
      // own address makes us talker, any other one idles us
      talk_q <= (din != `CMD_UNTALK) && (din[4:0] == PRIMARY_ADDR);  // see RULE17 see RULE19 see RULE27
    end
    // secondary group bytes fall through untouched, see RULE18
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || !ren)
    begin
      remote_q     <= 1'b0;
      llo_q        <= 1'b0;
      local_hold_q <= 1'b0;
    end
    else
    begin
      // go-to-local must stick, else remote comes straight back while enable is held
      if (is_local)
        local_hold_q <= 1'b1;
      else if (cmd && din == {`GRP_LISTEN, PRIMARY_ADDR})
        local_hold_q <= 1'b0;
      if (is_local)
        remote_q <= 1'b0;
      else if (!remote_q && !local_hold_q && !(i_local_key && !llo_q))
        remote_q <= 1'b1;  // see RULE2
      if (is_local && !i_lockout_cfg)
        llo_q <= 1'b0;
      else if (cmd && din == `CMD_LOCKOUT)
        llo_q <= 1'b1;  // see RULE8 see RULE9
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || ifc)
      poll_q <= 1'b0;
    else if (cmd && din == `CMD_POLL_ON)
      poll_q <= 1'b1;  // see RULE11
    else if (cmd && din == `CMD_POLL_OFF)
      poll_q <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_dev_clear    <= 1'b0;
      o_trigger      <= 1'b0;
      o_remote       <= 1'b0;
      o_lockout      <= 1'b0;
      o_panel_locked <= 1'b0;
      o_listener     <= 1'b0;
      o_talker       <= 1'b0;
      o_poll_mode    <= 1'b0;
    end
    else
    begin
      o_dev_clear    <= is_clear;
      o_trigger      <= cmd & listen_q & (din == `CMD_TRIGGER);  // see RULE15
      o_remote       <= remote_q;
      o_lockout      <= llo_q;
      // lockout config freezes all panel controls but the local key
      o_panel_locked <= remote_q & (llo_q | i_lockout_cfg);  // see RULE2
      o_listener     <= listen_q;
      o_talker       <= talk_q;
      o_poll_mode    <= poll_q;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer, two entries so a stalled reader loses nothing
  // ----------------------------------------------------------------
  bus_cmd_pkg::bus_byte_t rbuf [`BUF_DEPTH];
  logic [1:0] rcnt_q;
  logic       rwr_q, rrd_q;
  logic       push, pop;
  assign rxbuf_ready = (rcnt_q != 2'(`BUF_DEPTH));
  assign push        = take & ~atn & listen_q;  // see RULE20
  assign pop         = o_rx_valid & i_rx_ready;

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || is_clear)
    begin
      rcnt_q <= 2'h0;
      rwr_q  <= 1'b0;
      rrd_q  <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        rbuf[rwr_q] <= rx_byte;
        rwr_q       <= ~rwr_q;
      end
      if (pop)
        rrd_q <= ~rrd_q;
      rcnt_q <= rcnt_q + 2'(push) - 2'(pop);
    end
  end

  // output stage registered from the buffer head
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || is_clear)
    begin
      o_rx_valid <= 1'b0;
      o_rx       <= 9'h000;
    end
    else
    begin
      o_rx_valid <= (rcnt_q - 2'(pop)) != 2'h0;
      o_rx       <= rbuf[pop ? ~rrd_q : rrd_q];
    end
  end

  // ----------------------------------------------------------------
  // source handshake
  // ----------------------------------------------------------------
  logic src_go, tx_take;
  bus_cmd_pkg::bus_byte_t tx_byte;
  assign src_go  = talk_q & ~atn & (poll_q ? ~poll_sent_q : i_tx_valid);
  assign tx_take = (src_q == bus_cmd_pkg::SRC_IDLE) & src_go & ~poll_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || ifc || atn)
      src_q <= bus_cmd_pkg::SRC_IDLE;
    else
    begin
      unique case (src_q)
        bus_cmd_pkg::SRC_IDLE:  if (src_go) src_q <= bus_cmd_pkg::SRC_SETUP;
        bus_cmd_pkg::SRC_SETUP: if (!nrfd) src_q <= bus_cmd_pkg::SRC_VALID;  // see RULE23
        bus_cmd_pkg::SRC_VALID: if (!ndac) src_q <= bus_cmd_pkg::SRC_WAIT;
        bus_cmd_pkg::SRC_WAIT:  src_q <= bus_cmd_pkg::SRC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      tx_byte <= '{data: 8'h00, eoi: 1'b0};
    else if (src_q == bus_cmd_pkg::SRC_IDLE && src_go && poll_q)
      tx_byte <= '{data: {i_status[7], srq_q, i_status[5:0]}, eoi: 1'b0};  // see RULE26
    else if (src_q == bus_cmd_pkg::SRC_IDLE && src_go)
      tx_byte <= '{data: i_tx[8:1], eoi: i_tx[0]};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_tx_ready <= 1'b0;
    else
      o_tx_ready <= 1'b0 | (tx_take & ~o_tx_ready);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_dio_n  <= 8'hff;
      o_dio_oe <= 1'b0;
      o_dav_n  <= 1'b1;
      o_dav_oe <= 1'b0;
      o_eoi_n  <= 1'b1;
      o_eoi_oe <= 1'b0;
    end
    else
    begin
      o_dio_oe <= (src_q != bus_cmd_pkg::SRC_IDLE);
      o_dio_n  <= ~tx_byte.data;  // see RULE25
      o_dav_oe <= (src_q == bus_cmd_pkg::SRC_VALID);
      o_dav_n  <= ~(src_q == bus_cmd_pkg::SRC_VALID);
      o_eoi_oe <= (src_q != bus_cmd_pkg::SRC_IDLE) & tx_byte.eoi;  // see RULE4
      o_eoi_n  <= ~((src_q != bus_cmd_pkg::SRC_IDLE) & tx_byte.eoi);
    end
  end

  // ----------------------------------------------------------------
  // service request
  // ----------------------------------------------------------------
  // a new request in the read cycle wins over the clear
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || is_clear)
    begin
      srq_q       <= 1'b0;
      poll_sent_q <= 1'b0;
    end
    else
    begin
      if (i_srq_req)
        srq_q <= 1'b1;  // see RULE7
      else if (poll_q && src_q == bus_cmd_pkg::SRC_WAIT)
        srq_q <= 1'b0;  // see RULE26
      if (!poll_q || atn)
        poll_sent_q <= 1'b0;
      else if (src_q == bus_cmd_pkg::SRC_WAIT)
        poll_sent_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_srq_n  <= 1'b1;
      o_srq_oe <= 1'b0;
    end
    else
    begin
      o_srq_n  <= ~srq_q;
      o_srq_oe <= srq_q;
    end
  end

endmodule // bus_cmd_decoder

// ===== tb/bus_cmd_decoder_assertions.sv
// checker for the bus command decoder, bound to its ports
// assumes: bus pins are the resolved wire levels, sync to i_clk
`timescale 1ns/1ps
`include "bus_cmd_params.svh"

module bus_cmd_decoder_assertions
#(
  parameter logic [4:0] PRIMARY_ADDR = `ADDR_DEFAULT
)
(
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_atn_n,
  input wire logic       i_ifc_n,
  input wire logic       i_ren_n,
  input wire logic       i_dav_n,
  input wire logic [7:0] i_dio_n,
  input wire logic       i_srq_req,
  input wire logic       o_srq_n,
  input wire logic       o_srq_oe,
  input wire logic       o_lockout,
  input wire logic       o_listener,
  input wire logic       o_talker,
  input wire logic       o_poll_mode
);
  logic [7:0] cmd;
  logic [7:0] mla;
  logic [7:0] mta;

  assign cmd = ~i_dio_n;
  assign mla = {`GRP_LISTEN, PRIMARY_ADDR};
  assign mta = {`GRP_TALK, PRIMARY_ADDR};

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // --------------------------------
  // command bytes, interface clear and service request
  // --------------------------------
  // the source only drops dav once every acceptor is ready
  sequence taken_s(logic [7:0] b);
    $fell(i_dav_n) && !i_atn_n && cmd == b;
  endsequence

  sequence other_talk_s;
    $fell(i_dav_n) && !i_atn_n && cmd[7:5] == `GRP_TALK && cmd != mta;
  endsequence

  listen_own_a: assert property (taken_s(mla) |-> ##[1:4] o_listener)
    else $error("own listen address ignored");
  unlisten_a: assert property (taken_s(`CMD_UNLISTEN) |-> ##[1:4] !o_listener)
    else $error("listener kept after unlisten");
  talk_own_a: assert property (taken_s(mta) |-> ##[1:4] o_talker)
    else $error("own talk address ignored");
  other_talk_a: assert property (other_talk_s |-> ##[1:4] !o_talker)
    else $error("talker kept after other talk address");
  lockout_cmd_a: assert property (taken_s(`CMD_LOCKOUT) ##0 !i_ren_n |-> ##[1:4] o_lockout)
    else $error("lockout not entered");
  poll_on_a: assert property (taken_s(`CMD_POLL_ON) |-> ##[1:4] o_poll_mode)
    else $error("poll mode not entered");
  ifc_idle_a: assert property ($fell(i_ifc_n) |-> ##[1:3] !o_listener && !o_talker)
    else $error("interface clear left an address");
  srq_set_a: assert property ($rose(i_srq_req) |-> ##[1:3] o_srq_oe && !o_srq_n)
    else $error("service request not driven");
endmodule // bus_cmd_decoder_assertions

bind bus_cmd_decoder bus_cmd_decoder_assertions #(.PRIMARY_ADDR(PRIMARY_ADDR)) i_bus_cmd_decoder_assertions
(
  .i_clk, .i_resetn, .i_atn_n, .i_ifc_n, .i_ren_n, .i_dav_n, .i_dio_n, .i_srq_req,
  .o_srq_n, .o_srq_oe, .o_lockout, .o_listener, .o_talker, .o_poll_mode
);

// ===== tb/bus_ctl_model.sv
// bus controller stand-in: sources bytes and accepts bytes over the handshake
// assumes: inputs are resolved wire levels, active low
`timescale 1ns/1ps
module bus_ctl_model
(
  input  wire logic       i_clk,
  input  wire logic       i_dav_n,
  input  wire logic       i_nrfd_n,
  input  wire logic       i_ndac_n,
  input  wire logic       i_eoi_n,
  input  wire logic [7:0] i_dio_n,
  output logic            o_atn_n,
  output logic            o_eoi_n,
  output logic            o_dav_n,
  output logic            o_nrfd_n,
  output logic            o_ndac_n,
  output logic [7:0]      o_dio_n
);
  initial
  begin
    o_atn_n = 1'b1;
    o_eoi_n = 1'b1;
    o_dav_n = 1'b1;
    o_nrfd_n = 1'b0;
    o_ndac_n = 1'b0;
    o_dio_n = 8'hff;
  end

  // --------------------------------
  // transfers
  // --------------------------------
  // no local limit: a stuck handshake runs into the bench's cycle ceiling
  task automatic send(input logic atn, input logic [7:0] b, input logic e);
    @(posedge i_clk);
    o_atn_n <= ~atn;
    o_dio_n <= ~b;
    o_eoi_n <= ~e;
    o_nrfd_n <= 1'b1;
    o_ndac_n <= 1'b1;
    @(posedge i_clk);
    while (i_nrfd_n !== 1'b1) @(posedge i_clk);
    o_dav_n <= 1'b0;
    @(posedge i_clk);
    while (i_ndac_n !== 1'b1) @(posedge i_clk);
    // released lines float up to the terminator level
    o_dav_n <= 1'b1;
    o_eoi_n <= 1'b1;
    o_dio_n <= 8'hff;
  endtask

  task automatic recv(output logic [8:0] w);
    @(posedge i_clk);
    o_atn_n <= 1'b1;
    o_nrfd_n <= 1'b1;
    o_ndac_n <= 1'b0;
    @(posedge i_clk);
    while (i_dav_n !== 1'b0) @(posedge i_clk);
    w = {~i_dio_n, ~i_eoi_n};
    o_nrfd_n <= 1'b0;
    o_ndac_n <= 1'b1;
    @(posedge i_clk);
    while (i_dav_n !== 1'b1) @(posedge i_clk);
    o_ndac_n <= 1'b0;
  endtask
endmodule // bus_ctl_model

// ===== tb/tb.sv
// bench for the bus command decoder
// assumes: controller model on the wires, device at address 30, top of range
`timescale 1ns/1ps
module tb;
  localparam logic [4:0] PA  = 5'h1e;
  localparam logic [7:0] MLA = {3'h1, PA};
  localparam logic [7:0] MTA = {3'h2, PA};
  logic       i_clk = 1'b0, i_resetn = 1'b0, i_ifc_n = 1'b1, i_ren_n = 1'b1, i_srq_req = 1'b0;
  logic       i_tx_valid = 1'b0, i_rx_ready = 1'b1, i_atn_n, i_eoi_n, i_dav_n, i_nrfd_n, i_ndac_n;
  logic       i_lockout_cfg = 1'b0;
  logic       m_eoi, m_dav, m_nrfd, m_ndac, o_dio_oe, o_dav_n, o_dav_oe, o_eoi_n, o_eoi_oe, o_nrfd_n;
  logic       o_nrfd_oe, o_ndac_n, o_ndac_oe, o_srq_n, o_srq_oe, o_tx_ready, o_rx_valid, o_remote;
  logic       o_lockout, o_panel_locked, o_listener, o_talker, o_poll_mode, o_dev_clear, o_trigger;
  logic [7:0] i_dio_n, m_dio, o_dio_n;
  logic [8:0] i_tx = 9'h0, o_rx;
  logic [8:0] q[$];
  int         miscompares = 0, samples_checked = 0, n_trig = 0, n_clr = 0, cyc = 0;

  // wired-and: any party pulling low wins
  assign i_dio_n = m_dio & (o_dio_oe ? o_dio_n : 8'hff);
  assign i_eoi_n = m_eoi & (o_eoi_oe ? o_eoi_n : 1'b1);
  assign i_dav_n = m_dav & (o_dav_oe ? o_dav_n : 1'b1);
  assign i_nrfd_n = m_nrfd & (o_nrfd_oe ? o_nrfd_n : 1'b1);
  assign i_ndac_n = m_ndac & (o_ndac_oe ? o_ndac_n : 1'b1);

  bus_cmd_decoder #(.PRIMARY_ADDR(PA)) i_bus_cmd_decoder
  (
    .i_clk, .i_resetn, .i_atn_n, .i_ifc_n, .i_ren_n, .i_eoi_n, .i_dav_n, .i_nrfd_n, .i_ndac_n,
    .i_dio_n, .o_dio_n, .o_dio_oe, .o_dav_n, .o_dav_oe, .o_eoi_n, .o_eoi_oe, .o_nrfd_n, .o_nrfd_oe,
    .o_ndac_n, .o_ndac_oe, .o_srq_n, .o_srq_oe, .i_lockout_cfg, .i_local_key(1'b0), .i_srq_req,
    .i_status(8'h05), .i_tx, .i_tx_valid, .o_tx_ready, .o_rx, .o_rx_valid, .i_rx_ready, .o_remote,
    .o_lockout, .o_panel_locked, .o_listener, .o_talker, .o_poll_mode, .o_dev_clear, .o_trigger
  );

  bus_ctl_model i_bus_ctl_model
  (
    .i_clk, .i_dav_n, .i_nrfd_n, .i_ndac_n, .i_eoi_n, .i_dio_n, .o_atn_n(i_atn_n),
    .o_eoi_n(m_eoi), .o_dav_n(m_dav), .o_nrfd_n(m_nrfd), .o_ndac_n(m_ndac), .o_dio_n(m_dio)
  );

  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  // --------------------------------
  // monitors and helpers
  // --------------------------------
  always @(posedge i_clk)
  begin
    cyc++;
    if (o_trigger === 1'b1) n_trig++;
    if (o_dev_clear === 1'b1) n_clr++;
    if (o_rx_valid === 1'b1 && i_rx_ready) q.push_back(o_rx);
    if (o_tx_ready === 1'b1) i_tx_valid <= 1'b0;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // state flags follow decode by two cycles, trigger and clear pulses by one
  task automatic xfer(input logic atn, input logic [7:0] b, input logic e);
    i_bus_ctl_model.send(atn, b, e);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic cmd(input logic [7:0] b);
    xfer(1'b1, b, 1'b0);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    check("idle", {o_listener, o_talker, o_remote, o_lockout, o_poll_mode, o_dio_oe, o_dav_oe,
          o_srq_oe, o_nrfd_oe}, 9'h0);
  endtask

  task automatic t_remote;
    @(posedge i_clk) i_ren_n <= 1'b0;
    cmd(8'h3f);
    check("remote", o_remote, 9'h1);
    @(posedge i_clk) i_lockout_cfg <= 1'b1;
    repeat (2) @(negedge i_clk);
    check("cfg lock", {o_lockout, o_panel_locked}, 9'h1);
    @(posedge i_clk) i_lockout_cfg <= 1'b0;
    cmd(8'h11);
    check("lockout", {o_lockout, o_panel_locked}, 9'h3);
    cmd(MLA);
    cmd(8'h01);
    check("local", {o_remote, o_lockout}, 9'h0);
    @(posedge i_clk) i_ren_n <= 1'b1;
  endtask

  task automatic t_addr;
    int t0, c0;
    t0 = n_trig;
    c0 = n_clr;
    cmd(8'h3f);
    cmd(8'h08);
    check("trig unaddressed", 9'(n_trig - t0), 9'h0);
    cmd(MLA);
    cmd(8'h08);
    check("trig", 9'(n_trig - t0), 9'h1);
    cmd(8'h04);
    check("sel clear", 9'(n_clr - c0), 9'h1);
    cmd(8'h3f);
    cmd(8'h14);
    check("dev clear", 9'(n_clr - c0), 9'h2);
  endtask

  task automatic t_rx;
    q.delete();
    @(posedge i_clk) i_rx_ready <= 1'b0;
    cmd(8'h3f);
    cmd(MLA);
    check("listener", o_listener, 9'h1);
    xfer(1'b0, 8'h52, 1'b0);
    xfer(1'b0, 8'h58, 1'b1);
    check("stalled", {o_rx_valid, q.size() == 0}, 9'h3);
    @(posedge i_clk) i_rx_ready <= 1'b1;
    cmd(8'h3f);
    check("unlisten", o_listener, 9'h0);
    xfer(1'b0, 8'h30, 1'b0);
    check("count", 9'(q.size()), 9'h2);
    check("first", q[0], {8'h52, 1'b0});
    check("last", q[1], {8'h58, 1'b1});
  endtask

  task automatic t_talk;
    logic [8:0] w;
    cmd(MTA);
    check("talker", o_talker, 9'h1);
    cmd(8'h7e);
    check("secondary", o_talker, 9'h1);
    @(posedge i_clk) i_tx <= {8'h52, 1'b1};
    i_tx_valid <= 1'b1;
    i_bus_ctl_model.recv(w);
    check("talk byte", w, {8'h52, 1'b1});
    check("tx taken", i_tx_valid, 9'h0);
    cmd(MTA - 8'h01);
    check("other talk", o_talker, 9'h0);
    cmd(MTA);
    cmd(8'h5f);
    check("untalk", o_talker, 9'h0);
    cmd(MLA);
    cmd(MTA);
    @(posedge i_clk) i_ifc_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_ifc_n <= 1'b1;
    @(negedge i_clk);
    check("ifc", {o_listener, o_talker}, 9'h0);
  endtask

  task automatic t_poll;
    logic [8:0] w;
    @(posedge i_clk) i_srq_req <= 1'b1;
    @(posedge i_clk) i_srq_req <= 1'b0;
    repeat (2) @(negedge i_clk);
    check("srq on", {o_srq_oe, o_srq_n}, 9'h2);
    cmd(8'h18);
    check("poll", o_poll_mode, 9'h1);
    cmd(MTA);
    i_bus_ctl_model.recv(w);
    check("status", w[8:1], 9'h45);
    repeat (2) @(negedge i_clk);
    check("srq off", o_srq_oe & ~o_srq_n, 9'h0);
    cmd(8'h19);
    check("poll off", o_poll_mode, 9'h0);
  endtask

  initial
  begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    t_reset();
    t_remote();
    t_addr();
    t_rx();
    t_talk();
    t_poll();
    test_done();
  end
endmodule // tb
